// File: design/serial_cmd.sv
// Command interpreter holding per-port serial configuration behind APB
module serial_cmd
(
   // Clock and reset
   input  wire logic                             clk,
   input  wire logic                             rst,
   input  wire logic                             ce,
   // APB slave
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [11:0]                      paddr,
   input  wire logic [31:0]                      pwdata,
   output serial_cmd_pkg::apb_rsp_t              apb_rsp,
   // Serial engine events, one set per port
   input  serial_cmd_pkg::port_evt_t [3:0]       evt,
   // Configuration out to the serial engines
   output serial_cmd_pkg::port_cfg_t [3:0]       cfg
);
   import serial_cmd_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } fsm_t;

   typedef struct packed {
      fsm_t                   st;
      port_cfg_t [3:0]        cfg;
      logic [7:0]             cmd;
      logic [15:0]            p0;
      logic [15:0]            p1;
      logic [7:0]             test0;
      logic [7:0]             test1;
      logic                   busy;
      apb_rsp_t               rsp;
   } state_t;

   state_t q, d;

   // Cross-domain line status: three stages, change taken when 2nd and 3rd agree
   logic [3:0][3:0] ls_s1, ls_s2, ls_s3, ls_q;
   logic [3:0][3:0] ls_raw;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic port_cfg_t cfg_reset();
      port_cfg_t c;
      c          = '0;
      c.txbaud   = RST_BAUD;
      c.rxbaud   = RST_BAUD;
      c.parity   = RST_PAR;
      c.clen     = RST_CLEN;
      c.stopb    = RST_STOP;
      c.blk      = RST_BLK;
      c.start_th = RST_START;
      c.stop_th  = RST_STOPT;
      c.pchk     = RST_PCHK;
      return c;
   endfunction

   // Port number from command byte
   function automatic logic [1:0] port_of(input logic [7:0] c);
      return c[PORT_MSB:PORT_LSB];
   endfunction

   // ------------------------------------------------------------
   // Line-status pin synchronisers
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NPORTS; gi++)
      begin : g_sync
         assign ls_raw[gi] = {evt[gi].dtr_off, evt[gi].rts_off,
                              evt[gi].dsr_off, evt[gi].cts_off};
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               ls_s1[gi] <= 4'hF;
               ls_s2[gi] <= 4'hF;
               ls_s3[gi] <= 4'hF;
               ls_q[gi]  <= 4'hF;
            end
            else if (ce)
            begin
               ls_s1[gi] <= ls_raw[gi];
               ls_s2[gi] <= ls_s1[gi];
               ls_s3[gi] <= ls_s2[gi];
               // Only accept when the two late stages agree
               if (ls_s2[gi] == ls_s3[gi])
                  ls_q[gi] <= ls_s3[gi];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic [1:0]  pn;
      logic [5:0]  op;
      logic        wr_acc;
      logic        rd_acc;
      logic        err_clr;
      logic [7:0]  nerr;
      port_cfg_t   c;
      pn      = port_of(q.cmd);
      op      = q.cmd[5:0];
      c       = q.cfg[pn];
      d       = q;
      err_clr = 1'b0;
      nerr    = 8'h00;
      wr_acc  = psel && penable && pwrite;
      rd_acc  = psel && penable && !pwrite;
      d.rsp.pready  = 1'b0;
      d.rsp.pslverr = 1'b0;

      // Command execution, one cycle after the command write
      case (q.st)
         ST_IDLE:
         begin
            if (q.busy)
               d.st = ST_EXEC;
         end
         ST_EXEC:
         begin
            d.st   = ST_IDLE;
            d.busy = 1'b0;
            case (op)
               Q_TEST:   begin d.p0 = {8'h00, q.test1}; d.p1 = {8'h00, q.test0}; end
               Q_TXBAUD: begin d.p0 = {8'h00, c.txbaud}; d.p1 = '0; end
               Q_RXBAUD: begin d.p0 = {8'h00, c.rxbaud}; d.p1 = '0; end
               Q_PAR:    begin d.p0 = {8'h00, c.parity}; d.p1 = '0; end
               Q_CLEN:   begin d.p0 = {8'h00, c.clen};   d.p1 = '0; end
               Q_STOP:   begin d.p0 = {8'h00, c.stopb};  d.p1 = '0; end
               Q_RTS:    begin d.p0 = {8'h00, c.rts_mode}; d.p1 = {8'h00, c.cts_mon}; end
               Q_DTR:    begin d.p0 = {8'h00, c.dtr_mode}; d.p1 = {8'h00, c.dsr_mon}; end
               Q_PACE:   begin d.p0 = {8'h00, c.pace};   d.p1 = '0; end
               // Block size split as low byte / high nibble
               Q_BLK:    begin d.p0 = {8'h00, c.blk[7:0]}; d.p1 = {12'h000, c.blk[11:8]}; end
               Q_PMODE:  begin d.p0 = {8'h00, c.pmode};  d.p1 = '0; end
               Q_LINE:
               begin
                  d.p0 = '0;
                  d.p0[LS_XOFF_TX] = evt[pn].xoff_sent;
                  d.p0[LS_DTR]     = ls_q[pn][3];
                  d.p0[LS_RTS]     = ls_q[pn][2];
                  d.p0[LS_XOFF_RX] = c.xoff_rx;
                  d.p0[LS_DSR]     = ls_q[pn][1];
                  d.p0[LS_CTS]     = ls_q[pn][0];
                  d.p1 = '0;
               end
               Q_FIFO:   begin d.p0 = {8'h00, evt[pn].fifo_cnt[7:0]};
                               d.p1 = {13'h0000, evt[pn].fifo_cnt[10:8]}; end
               Q_ERR:    begin d.p0 = {8'h00, c.err}; d.p1 = '0; err_clr = 1'b1; end
               Q_RXCNT:  begin d.p0 = {8'h00, evt[pn].rx_cnt[7:0]};
                               d.p1 = {8'h00, evt[pn].rx_cnt[15:8]}; end
               Q_EMODE:  begin d.p0 = {8'h00, c.emode}; d.p1 = '0; end
               Q_START:  begin d.p0 = {8'h00, c.start_th[7:0]};
                               d.p1 = {8'h00, c.start_th[15:8]}; end
               Q_STOPT:  begin d.p0 = {8'h00, c.stop_th[7:0]};
                               d.p1 = {8'h00, c.stop_th[15:8]}; end
               Q_PCHK:   begin d.p0 = {8'h00, c.pchk}; d.p1 = '0; end
               S_TEST:   begin d.test0 = q.p0[7:0]; d.test1 = q.p1[7:0]; end
               S_TXBAUD: c.txbaud = q.p0[7:0];
               S_RXBAUD: c.rxbaud = q.p0[7:0];
               S_PAR:    c.parity = q.p0[7:0];
               S_CLEN:   c.clen   = q.p0[7:0];
               S_STOP:   c.stopb  = {4'h0, q.p0[3:0]};
               S_RTS:    begin c.rts_mode = q.p0[7:0]; c.cts_mon = q.p1[7:0]; end
               S_DTR:    begin c.dtr_mode = q.p0[7:0]; c.dsr_mon = q.p1[7:0]; end
               S_PACE:   c.pace   = q.p0[7:0];
               // Only p0[7:0] and p1[3:0] used; the upper bits of each word ignored
               S_BLK:    c.blk    = {q.p1[3:0], q.p0[7:0]};
               S_PMODE:  c.pmode  = q.p0[7:0];
               S_EMODE:  c.emode  = q.p0[7:0];
               S_START:  c.start_th = {q.p1[7:0], q.p0[7:0]};
               S_STOPT:  c.stop_th  = {q.p1[7:0], q.p0[7:0]};
               S_PCHK:   c.pchk   = q.p0[7:0];
               default:  ;
            endcase
         end
         default:
         begin
            d.st   = ST_IDLE;
            d.busy = 1'b0;
         end
      endcase

      // Write back the target port only
      if (q.st == ST_EXEC)
      begin
         if (err_clr)
            c.err = 8'h00;
         d.cfg[pn] = c;
      end

      // Sticky event flags; a set in the clearing cycle wins
      for (int i = 0; i < NPORTS; i++)
      begin
         nerr = d.cfg[i].err;
         nerr[ERR_FRAME]  = nerr[ERR_FRAME]  | evt[i].frame_err;
         nerr[ERR_PARITY] = nerr[ERR_PARITY] | evt[i].parity_err;
         nerr[ERR_OVFL]   = nerr[ERR_OVFL]   | evt[i].overflow;
         nerr[ERR_BFULL]  = nerr[ERR_BFULL]  | evt[i].buf_full;
         d.cfg[i].err = nerr & ERR_MASK;
         if (evt[i].xoff_seen)
            d.cfg[i].xoff_rx = 1'b1;
         else if (evt[i].xon_seen)
            d.cfg[i].xoff_rx = 1'b0;
      end

      // APB: answer registered one cycle into the access phase
      if (psel && penable && !q.rsp.pready)
      begin
         d.rsp.pready = 1'b1;
         d.rsp.prdata = '0;
         case (paddr)
            ADR_CMD:    d.rsp.prdata = {24'h000000, q.cmd};
            ADR_PARAM0: d.rsp.prdata = {16'h0000, q.p0};
            ADR_PARAM1: d.rsp.prdata = {16'h0000, q.p1};
            ADR_STATUS: d.rsp.prdata = {31'h00000000, q.busy};
            default:    d.rsp.pslverr = 1'b1;
         endcase
         if (rd_acc)
            d.rsp.prdata = d.rsp.prdata;
      end

      // Writes commit on the edge where the master sees pready, so a held request lands once
      if (wr_acc && q.rsp.pready)
      begin
         case (paddr)
            ADR_CMD:
            begin
               d.cmd  = pwdata[7:0];
               d.busy = 1'b1;
            end
            ADR_PARAM0: d.p0 = pwdata[15:0];
            ADR_PARAM1: d.p1 = pwdata[15:0];
            ADR_STATUS: ;
            default:    ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q       <= '0;
         q.st    <= ST_IDLE;
         q.test0 <= RST_TEST0;
         q.test1 <= RST_TEST1;
         for (int i = 0; i < NPORTS; i++)
            q.cfg[i] <= cfg_reset();
      end
      else if (ce)
         q <= d;
   end

   assign apb_rsp = q.rsp;
   assign cfg     = q.cfg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_port_select: assert property (@(posedge clk) disable iff (rst)
      (ce && q.st == ST_EXEC && q.cmd[5:0] == S_PAR) |=> (cfg[$past(q.cmd[7:6])].parity ==
      $past(q.p0[7:0]) || !$past(ce)))
      else $error("set parity not applied to selected port");
   a_test_swap: assert property (@(posedge clk) disable iff (rst)
      (ce && q.st == ST_EXEC && q.cmd[5:0] == Q_TEST) |=> (q.p0[7:0] == $past(q.test1)))
      else $error("test value not swapped");
   a_err_clear: assert property (@(posedge clk) disable iff (rst)
      (ce && q.st == ST_EXEC && q.cmd[5:0] == Q_ERR && !evt[q.cmd[7:6]].frame_err)
      |=> !cfg[$past(q.cmd[7:6])].err[ERR_FRAME])
      else $error("error flags not cleared by query");
   a_xoff_set: assert property (@(posedge clk) disable iff (rst)
      (ce && evt[3].xoff_seen) |=> cfg[3].xoff_rx)
      else $error("xoff received flag not set");
   a_blk_query: assert property (@(posedge clk) disable iff (rst)
      (ce && q.st == ST_EXEC && q.cmd[5:0] == Q_BLK) |=> (q.p1[15:4] == 12'h000))
      else $error("block size high bits not clear");
   a_apb_ready: assert property (@(posedge clk) disable iff (rst)
      (ce && psel && penable && !apb_rsp.pready) |=> apb_rsp.pready)
      else $error("apb answer late");
   a_result_hold: assert property (@(posedge clk) disable iff (rst)
      (q.st == ST_IDLE && !q.busy && !(psel && penable && pwrite)) |=> $stable(q.p0))
      else $error("result changed without command");
   a_stop_range: assert property (@(posedge clk) disable iff (rst)
      cfg[1].stopb[7:4] == 4'h0)
      else $error("stop code out of range");
endmodule

// File: design/serial_cmd_pkg.sv
// Constants, types and register map of the four-port serial command interpreter
package serial_cmd_pkg;

   // ------------------------------------------------------------
   // Register indices; each register is one aligned word
   // ------------------------------------------------------------
   localparam logic [11:0] OFF_CMD    = 12'h020;
   localparam logic [11:0] OFF_PARAM0 = 12'h022;
   localparam logic [11:0] OFF_PARAM1 = 12'h024;
   localparam logic [11:0] OFF_STATUS = 12'h028;
   // Byte addresses, four times the index
   localparam logic [11:0] ADR_CMD    = {OFF_CMD[9:0], 2'b00};
   localparam logic [11:0] ADR_PARAM0 = {OFF_PARAM0[9:0], 2'b00};
   localparam logic [11:0] ADR_PARAM1 = {OFF_PARAM1[9:0], 2'b00};
   localparam logic [11:0] ADR_STATUS = {OFF_STATUS[9:0], 2'b00};

   // ------------------------------------------------------------
   // Command field layout and codes
   // ------------------------------------------------------------
   localparam int          PORT_MSB = 7;
   localparam int          PORT_LSB = 6;
   localparam logic [5:0] Q_TEST  = 6'h00, Q_TXBAUD = 6'h01, Q_RXBAUD = 6'h02;
   localparam logic [5:0] Q_PAR   = 6'h03, Q_CLEN   = 6'h04, Q_STOP   = 6'h05;
   localparam logic [5:0] Q_RTS   = 6'h06, Q_DTR    = 6'h07, Q_PACE   = 6'h08;
   localparam logic [5:0] Q_BLK   = 6'h09, Q_PMODE  = 6'h0A, Q_LINE   = 6'h0B;
   localparam logic [5:0] Q_FIFO  = 6'h0C, Q_ERR    = 6'h0D, Q_RXCNT  = 6'h0E;
   localparam logic [5:0] Q_EMODE = 6'h13, Q_START  = 6'h14, Q_STOPT  = 6'h15;
   localparam logic [5:0] Q_PCHK  = 6'h1A;
   localparam logic [5:0] S_TEST  = 6'h20, S_TXBAUD = 6'h21, S_RXBAUD = 6'h22;
   localparam logic [5:0] S_PAR   = 6'h23, S_CLEN   = 6'h24, S_STOP   = 6'h25;
   localparam logic [5:0] S_RTS   = 6'h26, S_DTR    = 6'h27, S_PACE   = 6'h28;
   localparam logic [5:0] S_BLK   = 6'h29, S_PMODE  = 6'h2A, S_EMODE  = 6'h33;
   localparam logic [5:0] S_START = 6'h34, S_STOPT  = 6'h35, S_PCHK   = 6'h3A;

   // ------------------------------------------------------------
   // Reset values and field positions
   // ------------------------------------------------------------
   localparam logic [7:0]  RST_BAUD   = 8'h0B;
   localparam logic [7:0]  RST_PAR    = 8'h04;
   localparam logic [7:0]  RST_CLEN   = 8'h03;
   localparam logic [7:0]  RST_STOP   = 8'h07;
   localparam logic [11:0] RST_BLK    = 12'h800;
   localparam logic [15:0] RST_START  = 16'h2000;
   localparam logic [15:0] RST_STOPT  = 16'h2800;
   localparam logic [7:0]  RST_PCHK   = 8'h01;
   // Query returns value 1 first, so value 1 resets to 55 and value 0 to AA
   localparam logic [7:0]  RST_TEST0  = 8'hAA;
   localparam logic [7:0]  RST_TEST1  = 8'h55;
   localparam int          LS_XOFF_TX = 7;
   localparam int          LS_DTR     = 5;
   localparam int          LS_RTS     = 4;
   localparam int          LS_XOFF_RX = 3;
   localparam int          LS_DSR     = 1;
   localparam int          LS_CTS     = 0;
   localparam int          ERR_FRAME  = 6;
   localparam int          ERR_PARITY = 5;
   localparam int          ERR_OVFL   = 4;
   localparam int          ERR_BFULL  = 2;
   localparam logic [7:0]  ERR_MASK   = 8'h74;
   localparam int          NPORTS     = 4;

   // Per-port configuration set
   typedef struct packed {
      logic [7:0]  txbaud;
      logic [7:0]  rxbaud;
      logic [7:0]  parity;
      logic [7:0]  clen;
      logic [7:0]  stopb;
      logic [7:0]  rts_mode;
      logic [7:0]  cts_mon;
      logic [7:0]  dtr_mode;
      logic [7:0]  dsr_mon;
      logic [7:0]  pace;
      logic [11:0] blk;
      logic [7:0]  pmode;
      logic [7:0]  emode;
      logic [15:0] start_th;
      logic [15:0] stop_th;
      logic [7:0]  pchk;
      logic [7:0]  err;
      logic        xoff_rx;
   } port_cfg_t;

   // Line events from one serial engine
   typedef struct packed {
      logic        frame_err;
      logic        parity_err;
      logic        overflow;
      logic        buf_full;
      logic        xoff_seen;
      logic        xon_seen;
      logic        xoff_sent;
      logic        dtr_off;
      logic        rts_off;
      logic        dsr_off;
      logic        cts_off;
      logic [10:0] fifo_cnt;
      logic [15:0] rx_cnt;
   } port_evt_t;

   // APB answer bundle
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

endpackage

// File: verification/apb_host.sv
// Host model: APB master that loads parameters, issues commands, reads results
module apb_host
(
   // Clock
   input  wire logic                     clk,
   // APB master side
   output logic                          psel,
   output logic                          penable,
   output logic                          pwrite,
   output logic [11:0]                   paddr,
   output logic [31:0]                   pwdata,
   input  wire serial_cmd_pkg::apb_rsp_t apb_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   import serial_cmd_pkg::*;

   // ----------------------------------------
   // Bus idle at time zero
   // ----------------------------------------
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h00000000;
   end

   // One transfer; request held until pready is sampled high, no cycle count assumed
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (apb_rsp.pready !== 1'b1);
      r = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Full command: parameters first, then code, wait for idle, fetch both results
   task automatic cmd(input logic [7:0] c, input logic [7:0] p0, input logic [7:0] p1,
                      output logic [7:0] r0, output logic [7:0] r1);
      logic [31:0] r;
      logic        e;
      apb(1'b1, ADR_PARAM0, {24'h000000, p0}, r, e);
      apb(1'b1, ADR_PARAM1, {24'h000000, p1}, r, e);
      apb(1'b1, ADR_CMD, {24'h000000, c}, r, e);
      r = 32'h00000001;
      while (r[0] !== 1'b0)
         apb(1'b0, ADR_STATUS, 32'h00000000, r, e);
      apb(1'b0, ADR_PARAM0, 32'h00000000, r, e);
      r0 = r[7:0];
      apb(1'b0, ADR_PARAM1, 32'h00000000, r, e);
      r1 = r[7:0];
   endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the four-port serial command interpreter
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import serial_cmd_pkg::*;

   logic                   clk;
   logic                   rst;
   logic                   ce;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [11:0]            paddr;
   logic [31:0]            pwdata;
   apb_rsp_t               apb_rsp;
   port_evt_t [3:0]        evt;
   port_cfg_t [3:0]        cfg;
   int                     err_count;
   int                     cmp_count;
   int                     p, i, v, q, b;
   logic [7:0]             r0, r1, hi;
   logic [31:0]            rd;
   logic                   e;
   int                     mdl [4][14];
   // Query codes (settable first), value limits, reset values, two-byte flags
   int qc  [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A, 8'h13,
                    8'h14, 8'h15, 8'h1A, 8'h06, 8'h07};
   int lim [14] = '{13, 13, 5, 4, 16, 4, 0, 4, 2, 65536, 65536, 2, 0, 0};
   int rv  [14] = '{16'h000B, 16'h000B, 16'h0004, 16'h0003, 16'h0007, 16'h0000, 16'h0800,
                    16'h0000, 16'h0000, 16'h2000, 16'h2800, 16'h0001, 16'h0000, 16'h0000};
   bit two [14] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 1, 1, 0, 1, 1};

   serial_cmd i_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
                     .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .apb_rsp(apb_rsp),
                     .evt(evt), .cfg(cfg));
   apb_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
                    .paddr(paddr), .pwdata(pwdata), .apb_rsp(apb_rsp));

   // ----------------------------------------
   // Clock, checks and closing
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Query one port and compare against the expected result
   task automatic qry(input int pt, input logic [5:0] c, input bit w, input int exp);
      logic [7:0] a, z;
      i_host.cmd({pt[1:0], c}, 8'h00, 8'h00, a, z);
      chk(w ? {z, a} : {8'h00, a}, exp[15:0]);
   endtask

   task automatic test_done();
      if (err_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog well above the expected run length
   initial
   begin
      repeat (80000) @(posedge clk);
      err_count++;
      test_done();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      ce  = 1'b1;
      evt = '0;
      void'($urandom(32'h3A57E8AE));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Reset values on every port
      for (p = 0; p < 4; p++)
         for (i = 0; i < 14; i++)
         begin
            mdl[p][i] = rv[i];
            qry(p, qc[i][5:0], two[i], rv[i]);
         end
      qry(0, 6'h00, 1'b1, 16'hAA55);
      // Random settings; every port is read back so a stray port write shows
      repeat (40)
      begin
         p = $urandom_range(3, 0);
         i = $urandom_range(11, 0);
         v = (i == 6) ? $urandom_range(2048, 1) : $urandom_range(lim[i] - 1, 0);
         hi = v[15:8] | ((i == 6) ? 8'hA0 : 8'h00); // Unused block bits set on purpose
         i_host.cmd({p[1:0], qc[i][5:0] | 6'h20}, v[7:0], hi, r0, r1);
         mdl[p][i] = v;
         for (q = 0; q < 4; q++)
            qry(q, qc[i][5:0], two[i], mdl[q][i]);
      end
      // Handshake modes carry the monitor flag in the second parameter
      for (i = 12; i < 14; i++)
      begin
         p = $urandom_range(3, 0);
         v = $urandom_range(4, 0) | ($urandom_range(1, 0) << 8);
         i_host.cmd({p[1:0], qc[i][5:0] | 6'h20}, v[7:0], v[15:8], r0, r1);
         qry(p, qc[i][5:0], 1'b1, v);
      end
      // Test values come back swapped
      hi = $urandom_range(255, 0);
      i_host.cmd(8'h60, 8'h3C, hi, r0, r1);
      qry(1, 6'h00, 1'b1, {8'h3C, hi});
      // Each error flag on its own port, cleared by the read
      for (b = 0; b < 4; b++)
      begin
         @(posedge clk);
         {evt[b].frame_err, evt[b].parity_err, evt[b].overflow, evt[b].buf_full} <= 4'h8 >> b;
         @(posedge clk);
         evt[b] <= '0;
         qry(b, 6'h0D, 1'b0, 8'h40 >> b + (b == 3 ? 1 : 0));
         qry(b, 6'h0D, 1'b0, 0);
      end
      // Clock enable low freezes state, so an error pulse then is lost
      @(posedge clk);
      ce <= 1'b0;
      evt[0].frame_err <= 1'b1;
      @(posedge clk);
      evt[0].frame_err <= 1'b0;
      @(posedge clk);
      ce <= 1'b1;
      qry(0, 6'h0D, 1'b0, 0);
      // Line states and pacing; xoff and xon together keep xoff
      @(posedge clk);
      evt[3].rts_off   <= 1'b1;
      evt[3].cts_off   <= 1'b1;
      evt[3].xoff_sent <= 1'b1;
      evt[3].xoff_seen <= 1'b1;
      evt[3].xon_seen  <= 1'b1;
      @(posedge clk);
      evt[3].xoff_seen <= 1'b0;
      evt[3].xon_seen  <= 1'b0;
      qry(3, 6'h0B, 1'b0, 8'h99);
      qry(2, 6'h0B, 1'b0, 8'h00);
      @(posedge clk);
      evt[3].xon_seen <= 1'b1;
      @(posedge clk);
      evt[3].xon_seen <= 1'b0;
      qry(3, 6'h0B, 1'b0, 8'h91);
      // Receive counts
      v = $urandom_range(2047, 0);
      q = $urandom_range(65535, 0);
      @(posedge clk);
      evt[1].fifo_cnt <= v[10:0];
      evt[1].rx_cnt   <= q[15:0];
      repeat (2) @(posedge clk);
      qry(1, 6'h0C, 1'b1, v);
      qry(1, 6'h0E, 1'b1, q);
      // Unmapped address is refused
      i_host.apb(1'b0, 12'h030, 32'h00000000, rd, e);
      chk({15'h0000, e}, 16'h0001);
      test_done();
   end
endmodule
